// ### hdl/dhp_host_port_ctrl.sv
// Host port control: drive status overrides, interrupt, busy and gating
`timescale 1ns/10ps
// Operation
// - Drive-0 write fault follows firmware; cleared by host command with drive 0.
// - Drive-0 not-ready override forces not ready; cleared by command with drive 0.
// - Drive-1 seek complete follows firmware; set by host command with drive 1.
// - Drive-1 write fault follows firmware; cleared by host command with drive 1.
// - Drive-1 not-ready override forces not ready; cleared by command with drive 1.
// - Writing 1 to drive bit 6 raises interrupt and clears busy.
// - Drive bit 7 sets or clears busy; with it set, command writes raise busy.
// - Control registers zero at reset and at host soft reset.
// - Control bit 0 low blocks the 16-bit select output.
// - Control bit 1 low keeps channel-ready asserted.
// - Control bit 2 lets local transfer interrupt raise busy.
// - Control bit 3 floats interrupt outside commands; host disable wins.
// - Control bit 4 keeps transfer running across transfer interrupts.
// - Control bit 6 picks local transfer direction.
// - Control bit 7 enables requests, data request, self-clears at count end.
// - Aux bit 4 selects full or half reference clock.
// - Aux bits 5-7 give hold clocks for channel-ready, reset zero.
// - Status bits 0 and 1 mirror interrupt and busy.
// - Status bit 2 set by command write, cleared by reset or firmware.
// - In master mode status bits 3 and 4 invert slave inputs.
// - Status bit 5 set by host soft reset, cleared on status read.
// - Drive-0 seek complete follows firmware; set by command with drive 0.
module dhp_host_port_ctrl (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire dhp_pkg::dhp_avs_req_t avsReq,
  output      dhp_pkg::dhp_avs_rsp_t avsRsp,
  input  wire dhp_pkg::dhp_host_pins_t hostPins,
  input  wire logic [1:0]           driveReadyN,
  input  wire logic                 cmdInN,
  input  wire logic                 slavePassInput,
  input  wire logic                 masterMode,
  input  wire logic                 localXferDoneIrq,
  input  wire logic                 xferCountDone,
  input  wire logic                 fifoHasData,
  input  wire logic                 dataAvailable,
  input  wire logic                 wordXfer,
  input  wire logic                 cmdFlagClr,
  output      logic                 hostIrq,
  output      logic                 hostIrqOeN,
  output      logic                 hostBusy,
  output      logic                 hostDrq,
  output      logic                 ioCs16N,
  output      logic                 ioChRdy,
  output      logic                 xferEnable,
  output      logic                 xferDirToFifo,
  output      logic [1:0]           seekDone,
  output      logic [1:0]           writeFault,
  output      logic [1:0]           driveNotReady,
  output      logic                 diagActive,
  output      logic                 diagPassed
);
  import dhp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]     ifCtrl;
    logic [7:0]     auxCtrl;
    logic [7:0]     drvOvr;
    logic           irq;
    logic           irqOeN;
    logic           irqLive;
    logic           irqDis;
    logic           busy;
    logic           drq;
    logic           cmdSeen;
    logic           softRstSeen;
    logic           dmaSeen;
    logic           drvSel;
    logic           cs16N;
    logic           chRdy;
    logic [1:0]     notRdy;
    logic           waitReq;
    logic [7:0]     rdData;
    dhp_host_pins_t prevPins;
  } dhp_main_st_t;

  dhp_main_st_t   st_ff;
  dhp_main_st_t   nxt_st;
  dhp_host_pins_t pinsSync;
  logic [1:0]     readyNSync;
  logic           cmdInNSync;
  logic           slavePassSync;
  logic           holdActive;
  logic           cs16Start;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  dhp_sync #(
    .WIDTH($bits(dhp_host_pins_t))
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (hostPins),
    .syncOut  (pinsSync)
  );

  dhp_sync #(
    .WIDTH(4)
  ) u_misc_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({driveReadyN, cmdInN, slavePassInput}),
    .syncOut  ({readyNSync, cmdInNSync, slavePassSync})
  );

  // ****************************************
  // Pre channel-ready hold counter
  // ****************************************
  assign cs16Start = st_ff.cs16N & ~nxt_st.cs16N;

  dhp_pre_rdy_cnt u_pre_rdy (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (cs16Start),
    .count    (st_ff.auxCtrl[AC_CNT_MSB:AC_CNT_LSB]),
    .fullRate (st_ff.auxCtrl[AC_REFSEL]),
    .holding  (holdActive)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic       hostWrEv;
    logic       hostRdEv;
    logic       cmdWr;
    logic       sdhWr;
    logic       hctlWr;
    logic       statRd;
    logic       dataAcc;
    logic       avsAck;
    logic       fwWr;
    logic       fwRd;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] statusByte;

    nxt_st     = st_ff;
    idx        = 8'h00;
    wd         = avsReq.writedata[7:0];
    statusByte = 8'h00;

    // Host strobes act on their rising edge, decoded from the held pins
    hostWrEv = ~st_ff.prevPins.wrN & pinsSync.wrN;
    hostRdEv = ~st_ff.prevPins.rdN & pinsSync.rdN;
    cmdWr    = hostWrEv & ~st_ff.prevPins.cs0N & (st_ff.prevPins.addr == HA_CMD);
    sdhWr    = hostWrEv & ~st_ff.prevPins.cs0N & (st_ff.prevPins.addr == HA_SDH);
    hctlWr   = hostWrEv & ~st_ff.prevPins.cs1N & (st_ff.prevPins.addr == HA_HCTL);
    statRd   = hostRdEv & ~st_ff.prevPins.cs0N & (st_ff.prevPins.addr == HA_CMD);
    dataAcc  = ~pinsSync.cs0N & (pinsSync.addr == HA_DATA) & ~(pinsSync.rdN & pinsSync.wrN);
    nxt_st.prevPins = pinsSync;

    // Bus slave: one wait cycle, then the access completes
    avsAck = (avsReq.read | avsReq.write) & st_ff.waitReq;
    nxt_st.waitReq = ~avsAck;
    if (avsReq.address[1:0] == 2'b00)
      idx = avsReq.address[9:2];
    else
      idx = 8'hFF;
    fwWr = avsReq.write & ~st_ff.waitReq;
    fwRd = avsReq.read & ~st_ff.waitReq;

    statusByte[0] = st_ff.irq;
    statusByte[1] = st_ff.busy;
    statusByte[2] = st_ff.cmdSeen;
    statusByte[3] = masterMode & ~cmdInNSync;
    statusByte[4] = masterMode & ~slavePassSync;
    statusByte[5] = st_ff.softRstSeen;
    statusByte[6] = st_ff.dmaSeen;

    if (avsAck)
    begin
      case (idx)
        IDX_IF_STATUS: nxt_st.rdData = statusByte;
        IDX_DRV_OVR:   nxt_st.rdData = st_ff.drvOvr;
        IDX_IF_CTRL:   nxt_st.rdData = st_ff.ifCtrl;
        IDX_AUX_CTRL:  nxt_st.rdData = st_ff.auxCtrl;
        default:       nxt_st.rdData = 8'h00;
      endcase
    end

    // ****************************************
    // Firmware writes and clears first, so hardware sets win
    // ****************************************
    if (fwWr)
    begin
      case (idx)
        IDX_IF_CTRL:
        begin
          nxt_st.ifCtrl  = wd & IF_CTRL_WMASK;
          nxt_st.dmaSeen = 1'b0;
        end
        IDX_AUX_CTRL: nxt_st.auxCtrl = wd;
        IDX_DRV_OVR:
        begin
          nxt_st.drvOvr = wd & ~(8'h01 << DO_IRQ);
          nxt_st.busy = wd[DO_BUSY];
          if (wd[DO_IRQ])
          begin
            nxt_st.irq  = 1'b1;
            nxt_st.busy = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (fwRd && idx == IDX_IF_STATUS)
      nxt_st.softRstSeen = 1'b0;
    if (cmdFlagClr)
      nxt_st.cmdSeen = 1'b0;

    // ****************************************
    // Host-side events
    // ****************************************
    if (sdhWr)
      nxt_st.drvSel = st_ff.prevPins.data[SDH_DRV];
    if (cmdWr)
    begin
      nxt_st.cmdSeen = 1'b1;
      nxt_st.irqLive = 1'b1;
      nxt_st.irq     = 1'b0;
      if (st_ff.drvOvr[DO_BUSY])
        nxt_st.busy = 1'b1;
      if (!st_ff.drvSel)
      begin
        nxt_st.drvOvr[DO_SEEK0] = 1'b1;
        nxt_st.drvOvr[DO_WF0] = 1'b0;
        nxt_st.drvOvr[DO_NRDY0] = 1'b0;
      end
      else
      begin
        nxt_st.drvOvr[DO_SEEK1] = 1'b1;
        nxt_st.drvOvr[DO_WF1] = 1'b0;
        nxt_st.drvOvr[DO_NRDY1] = 1'b0;
      end
    end
    // A host status read drops the interrupt; with busy low it also ends the command
    if (statRd)
    begin
      nxt_st.irq = 1'b0;
      if (!nxt_st.busy)
        nxt_st.irqLive = 1'b0;
    end
    if (hctlWr)
    begin
      nxt_st.irqDis = st_ff.prevPins.data[HCTL_NIEN];
      if (st_ff.prevPins.data[HCTL_SRST])
      begin
        nxt_st.ifCtrl  = RST_IF_CTRL;
        nxt_st.auxCtrl = RST_AUX_CTRL;
        nxt_st.softRstSeen = 1'b1;
      end
    end

    // ****************************************
    // Local transfer engine
    // ****************************************
    if (localXferDoneIrq)
    begin
      nxt_st.dmaSeen = 1'b1;
      if (nxt_st.ifCtrl[IC_DMABSY])
        nxt_st.busy = 1'b1;
      // Without multi mode the transfer stops
      if (!nxt_st.ifCtrl[IC_MULTI])
        nxt_st.ifCtrl[IC_XFER_EN] = 1'b0;
    end
    if (xferCountDone)
      nxt_st.ifCtrl[IC_XFER_EN] = 1'b0;
    // Data request once the FIFO holds data
    nxt_st.drq = st_ff.ifCtrl[IC_XFER_EN] & fifoHasData;

    // ****************************************
    // Host bus outputs
    // ****************************************
    // Host disable wins; tri-state mode floats outside commands
    nxt_st.irqOeN = nxt_st.irqDis | (nxt_st.ifCtrl[IC_IRQTRI] & ~nxt_st.irqLive);
    nxt_st.cs16N = ~(st_ff.ifCtrl[IC_CS16] & wordXfer & dataAcc);
    nxt_st.chRdy = ~(st_ff.ifCtrl[IC_CHRDY] & dataAcc & (~dataAvailable | holdActive));
    nxt_st.notRdy[0] = st_ff.drvOvr[DO_NRDY0] | readyNSync[0];
    nxt_st.notRdy[1] = st_ff.drvOvr[DO_NRDY1] | readyNSync[1];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff         <= '0;
      st_ff.ifCtrl  <= RST_IF_CTRL;
      st_ff.auxCtrl <= RST_AUX_CTRL;
      st_ff.drvOvr  <= RST_DRV_OVR;
      st_ff.cs16N   <= 1'b1;
      st_ff.chRdy   <= 1'b1;
      st_ff.waitReq <= 1'b1;
      st_ff.notRdy  <= 2'b11;
      st_ff.prevPins <= '1;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs, all from state flops
  // ****************************************
  assign avsRsp.waitrequest = st_ff.waitReq;
  assign avsRsp.readdata    = {24'h000000, st_ff.rdData};
  assign hostIrq       = st_ff.irq;
  assign hostIrqOeN    = st_ff.irqOeN;
  assign hostBusy      = st_ff.busy;
  assign hostDrq       = st_ff.drq;
  assign ioCs16N       = st_ff.cs16N;
  assign ioChRdy       = st_ff.chRdy;
  assign xferEnable    = st_ff.ifCtrl[IC_XFER_EN];
  // Direction: 1 moves RAM into FIFO
  assign xferDirToFifo = st_ff.ifCtrl[IC_DIR];
  assign seekDone      = {st_ff.drvOvr[DO_SEEK1], st_ff.drvOvr[DO_SEEK0]};
  assign writeFault    = {st_ff.drvOvr[DO_WF1], st_ff.drvOvr[DO_WF0]};
  assign driveNotReady = st_ff.notRdy;
  assign diagActive    = st_ff.auxCtrl[AC_DIAG];
  assign diagPassed    = st_ff.auxCtrl[AC_PASS];

endmodule : dhp_host_port_ctrl

// ### hdl/dhp_pkg.sv
// Shared constants and carrier types for the disk host port control block
package dhp_pkg;

  // ****************************************
  // Register bus geometry
  // ****************************************
  localparam int unsigned AVS_ADDR_W = 10;
  localparam int unsigned AVS_DATA_W = 32;
  localparam int unsigned BYTE_PER_IDX = 4;

  // Register indices; byte address is index times four
  localparam logic [7:0] IDX_IF_STATUS = 8'h40;
  localparam logic [7:0] IDX_DRV_OVR   = 8'h4B;
  localparam logic [7:0] IDX_IF_CTRL   = 8'h4C;
  localparam logic [7:0] IDX_AUX_CTRL  = 8'h4D;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_IF_CTRL  = 8'h00;
  localparam logic [7:0] RST_AUX_CTRL = 8'h00;
  localparam logic [7:0] RST_DRV_OVR  = 8'h00;
  localparam logic [7:0] IF_CTRL_WMASK = 8'hDF;

  // ****************************************
  // Field positions
  // ****************************************
  // drive_status_override
  localparam int unsigned DO_SEEK0 = 0;
  localparam int unsigned DO_WF0   = 1;
  localparam int unsigned DO_NRDY0 = 2;
  localparam int unsigned DO_SEEK1 = 3;
  localparam int unsigned DO_WF1   = 4;
  localparam int unsigned DO_NRDY1 = 5;
  localparam int unsigned DO_IRQ   = 6;
  localparam int unsigned DO_BUSY  = 7;
  // interface_control
  localparam int unsigned IC_CS16    = 0;
  localparam int unsigned IC_CHRDY   = 1;
  localparam int unsigned IC_DMABSY  = 2;
  localparam int unsigned IC_IRQTRI  = 3;
  localparam int unsigned IC_MULTI   = 4;
  localparam int unsigned IC_DIR     = 6;
  localparam int unsigned IC_XFER_EN = 7;
  // aux_control
  localparam int unsigned AC_DIAG    = 0;
  localparam int unsigned AC_PASS    = 1;
  localparam int unsigned AC_REFSEL  = 4;
  localparam int unsigned AC_CNT_LSB = 5;
  localparam int unsigned AC_CNT_MSB = 7;
  // host-side decode
  localparam logic [2:0] HA_DATA = 3'h0;
  localparam logic [2:0] HA_SDH  = 3'h6;
  localparam logic [2:0] HA_CMD  = 3'h7;
  localparam logic [2:0] HA_HCTL = 3'h6;
  localparam int unsigned SDH_DRV    = 4;
  localparam int unsigned HCTL_NIEN  = 1;
  localparam int unsigned HCTL_SRST  = 2;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [AVS_ADDR_W-1:0] address;
    logic [AVS_DATA_W-1:0] writedata;
  } dhp_avs_req_t;

  typedef struct packed {
    logic                  waitrequest;
    logic [AVS_DATA_W-1:0] readdata;
  } dhp_avs_rsp_t;

  // Host bus pins, all active low except address and data
  typedef struct packed {
    logic       wrN;
    logic       rdN;
    logic       cs0N;
    logic       cs1N;
    logic [2:0] addr;
    logic [7:0] data;
  } dhp_host_pins_t;

endpackage : dhp_pkg

// ### hdl/dhp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module dhp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output      logic [WIDTH-1:0] syncOut
);
  import dhp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dhp_sync_st_t;

  dhp_sync_st_t st_ff;
  dhp_sync_st_t nxt_st;

  // Stage one feeds stage two only
  always_comb
  begin
    nxt_st.meta   = asyncIn;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    // Idle level of the active-low pins, so no false edge follows reset
    if (rst)
      st_ff <= '1;
    else
      st_ff <= nxt_st;
  end

  assign syncOut = st_ff.stable;

endmodule : dhp_sync

// ### hdl/dhp_pre_rdy_cnt.sv
// Hold counter that keeps channel-ready low after the 16-bit select
`timescale 1ns/10ps
module dhp_pre_rdy_cnt (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [2:0] count,
  input  wire logic       fullRate,
  output      logic       holding
);
  import dhp_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic       half;
  } dhp_cnt_st_t;

  dhp_cnt_st_t st_ff;
  dhp_cnt_st_t nxt_st;
  logic        refTick;

  assign refTick = fullRate | st_ff.half;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.half = ~st_ff.half;
    if (start)
    begin
      nxt_st.cnt  = count;
      nxt_st.half = 1'b0;
    end
    else if (refTick && st_ff.cnt != 3'h0)
      nxt_st.cnt = st_ff.cnt - 3'h1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign holding = (st_ff.cnt != 3'h0);

endmodule : dhp_pre_rdy_cnt

// ### tb/dhp_host_port_ctrl_properties.sv
// Concurrent checks on the host port control ports
`timescale 1ns/10ps
module dhp_host_port_ctrl_properties (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire dhp_pkg::dhp_avs_req_t avsReq,
  input wire dhp_pkg::dhp_avs_rsp_t avsRsp,
  input wire logic [1:0]            driveReadyN,
  input wire logic                  localXferDoneIrq,
  input wire logic                  xferCountDone,
  input wire logic                  wordXfer,
  input wire logic                  hostIrq,
  input wire logic                  hostBusy,
  input wire logic                  ioCs16N,
  input wire logic                  xferEnable,
  input wire logic                  xferDirToFifo,
  input wire logic [1:0]            seekDone,
  input wire logic [1:0]            writeFault,
  input wire logic [1:0]            driveNotReady,
  input wire logic                  diagActive
);
  import dhp_pkg::*;
  logic       done;
  logic [7:0] idx;
  logic [7:0] wd;
  logic [7:0] wd_ff;
  assign done = !avsRsp.waitrequest;
  assign idx  = avsReq.address[9:2];
  assign wd   = avsReq.writedata[7:0];
  // Write data of the previous cycle, for checks one cycle after completion
  always_ff @(posedge core_clk)
    wd_ff <= wd;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_IRQ_SET: assert property (
    avsReq.write && done && idx == IDX_DRV_OVR && wd[DO_IRQ] && !localXferDoneIrq
    |=> hostIrq && !hostBusy) else $error("Irq one-shot missed");
  AST_BUSY_WR: assert property (
    avsReq.write && done && idx == IDX_DRV_OVR && !wd[DO_IRQ] && !localXferDoneIrq
    |=> hostBusy == wd_ff[DO_BUSY]) else $error("Busy does not follow drive write");
  AST_STAT_MIRROR: assert property (
    avsReq.read && done && idx == IDX_IF_STATUS
    |-> avsRsp.readdata[1] == $past(hostBusy) && avsRsp.readdata[0] == $past(hostIrq))
    else $error("Status irq or busy bit wrong");
  AST_DIR_WR: assert property (
    avsReq.write && done && idx == IDX_IF_CTRL |=> xferDirToFifo == wd_ff[IC_DIR])
    else $error("Direction not taken from control write");
  AST_DRV_FIELDS: assert property (
    avsReq.write && done && idx == IDX_DRV_OVR
    |=> writeFault == {wd_ff[DO_WF1], wd_ff[DO_WF0]}
        && seekDone == {wd_ff[DO_SEEK1], wd_ff[DO_SEEK0]})
    else $error("Drive fields not updated");
  AST_AUX_DIAG: assert property (
    avsReq.write && done && idx == IDX_AUX_CTRL |=> diagActive == wd_ff[AC_DIAG])
    else $error("Diagnostic bit not updated");
  AST_XFER_END: assert property (
    xferCountDone && xferEnable |=> !xferEnable) else $error("Transfer not ended");
  AST_NRDY_PIN: assert property (
    driveReadyN == 2'h3 [*4] |-> driveNotReady == 2'h3) else $error("Ready pin ignored");
  AST_CS16_WORD: assert property (
    !wordXfer [*3] |-> ioCs16N) else $error("Wide select without word transfer");
endmodule : dhp_host_port_ctrl_properties

bind dhp_host_port_ctrl dhp_host_port_ctrl_properties u_props (
  .core_clk(core_clk), .rst(rst), .avsReq(avsReq), .avsRsp(avsRsp),
  .driveReadyN(driveReadyN), .localXferDoneIrq(localXferDoneIrq),
  .xferCountDone(xferCountDone), .wordXfer(wordXfer), .hostIrq(hostIrq),
  .hostBusy(hostBusy), .ioCs16N(ioCs16N), .xferEnable(xferEnable),
  .xferDirToFifo(xferDirToFifo), .seekDone(seekDone), .writeFault(writeFault),
  .driveNotReady(driveNotReady), .diagActive(diagActive));

// ### tb/dhp_host_model.sv
// Host processor model driving the parallel bus pins
`timescale 1ns/10ps
module dhp_host_model (
  input wire logic                core_clk,
  output dhp_pkg::dhp_host_pins_t hostPins
);
  import dhp_pkg::*;
  initial
    hostPins = '{wrN: 1'b1, rdN: 1'b1, cs0N: 1'b1, cs1N: 1'b1, addr: 3'h0, data: 8'hFF};
  // Strobe held four clocks each way, beyond the three-clock minimum
  task automatic access(input logic wr, input logic cs1, input logic [2:0] a,
                        input logic [7:0] d);
    @(posedge core_clk);
    hostPins <= '{wrN: 1'b1, rdN: 1'b1, cs0N: cs1, cs1N: !cs1, addr: a, data: d};
    repeat (2) @(posedge core_clk);
    hostPins.wrN <= !wr;
    hostPins.rdN <= wr;
    repeat (4) @(posedge core_clk);
    hostPins.wrN <= 1'b1;
    hostPins.rdN <= 1'b1;
    repeat (2) @(posedge core_clk);
    // Released bus shows the inverse, so a stale byte cannot pass
    hostPins <= '{wrN: 1'b1, rdN: 1'b1, cs0N: 1'b1, cs1N: 1'b1, addr: ~a, data: ~d};
    repeat (4) @(posedge core_clk);
  endtask : access
endmodule : dhp_host_model

// ### tb/tb_top.sv
// Self-checking bench for the host port control block
`timescale 1ns/10ps
module tb_top;
  import dhp_pkg::*;
  logic           core_clk;
  logic           rst;
  dhp_avs_req_t   avsReq;
  dhp_avs_rsp_t   avsRsp;
  dhp_host_pins_t hostPins;
  logic [1:0]     driveReadyN, seekDone, writeFault, driveNotReady;
  logic           cmdInN, slavePassInput, masterMode, localXferDoneIrq, xferCountDone;
  logic           fifoHasData, dataAvailable, wordXfer, cmdFlagClr, hostIrq, hostIrqOeN;
  logic           hostBusy, hostDrq, ioCs16N, ioChRdy, xferEnable, xferDirToFifo;
  logic           diagActive, diagPassed, sawCs16, sawWait;
  logic [31:0]    rd, seed;
  logic [7:0]     v, e;
  int             err_total, tests_run;

  dhp_host_port_ctrl dut (
    .core_clk(core_clk), .rst(rst), .avsReq(avsReq), .avsRsp(avsRsp), .hostPins(hostPins),
    .driveReadyN(driveReadyN), .cmdInN(cmdInN), .slavePassInput(slavePassInput),
    .masterMode(masterMode), .localXferDoneIrq(localXferDoneIrq),
    .xferCountDone(xferCountDone), .fifoHasData(fifoHasData), .dataAvailable(dataAvailable),
    .wordXfer(wordXfer), .cmdFlagClr(cmdFlagClr), .hostIrq(hostIrq), .hostIrqOeN(hostIrqOeN),
    .hostBusy(hostBusy), .hostDrq(hostDrq), .ioCs16N(ioCs16N), .ioChRdy(ioChRdy),
    .xferEnable(xferEnable), .xferDirToFifo(xferDirToFifo), .seekDone(seekDone),
    .writeFault(writeFault), .driveNotReady(driveNotReady), .diagActive(diagActive),
    .diagPassed(diagPassed));
  dhp_host_model host (.core_clk(core_clk), .hostPins(hostPins));

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Override bits after a host command for the selected drive
  function automatic logic [7:0] drvAfterCmd(input logic [7:0] o, input logic d1);
    if (d1)
      return (o & 8'hC7) | 8'h08;
    return (o & 8'hF8) | 8'h01;
  endfunction : drvAfterCmd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low at a rising edge
  task automatic avs(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avsReq <= '{read: !wr, write: wr, address: {idx, 2'h0}, writedata: {24'h0, wd}};
    do
      @(posedge core_clk);
    while (avsRsp.waitrequest !== 1'b0 && ++n < 50);
    rd = avsRsp.readdata;
    avsReq <= '0;
    if (n >= 50)
      check(32'h0, 32'h1);
    repeat (2) @(negedge core_clk);
  endtask : avs

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    avs(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask : rdChk

  // k: 2 transfer irq, 1 count end, 0 command flag clear
  task automatic pulse(input int k);
    @(posedge core_clk);
    {localXferDoneIrq, xferCountDone, cmdFlagClr} <= 3'(1 << k);
    @(posedge core_clk);
    {localXferDoneIrq, xferCountDone, cmdFlagClr} <= 3'h0;
    repeat (2) @(negedge core_clk);
  endtask : pulse

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  always @(posedge core_clk)
  begin
    if (ioCs16N === 1'b0)
      sawCs16 <= 1'b1;
    if (ioChRdy === 1'b0)
      sawWait <= 1'b1;
  end

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #100000;
    check(32'h0, 32'h1);
    complete_run();
  end

  // ********
  // Scenarios
  // ********
  initial
  begin
    rst = 1'b1;
    avsReq = '0;
    {driveReadyN, cmdInN, slavePassInput, masterMode, localXferDoneIrq, xferCountDone} = 7'h18;
    {fifoHasData, dataAvailable, wordXfer, cmdFlagClr, sawCs16, sawWait} = 6'h0;
    err_total = 0;
    tests_run = 0;
    seed = 32'h2049;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(IDX_IF_CTRL, RST_IF_CTRL);
    rdChk(IDX_AUX_CTRL, RST_AUX_CTRL);
    rdChk(IDX_DRV_OVR, RST_DRV_OVR);
    repeat (6)
    begin
      seed = xs(seed);
      avs(1'b1, IDX_IF_CTRL, seed[7:0]);
      check(xferDirToFifo, seed[IC_DIR]);
      rdChk(IDX_IF_CTRL, seed[7:0] & IF_CTRL_WMASK);
      avs(1'b1, IDX_AUX_CTRL, seed[15:8]);
      rdChk(IDX_AUX_CTRL, seed[15:8]);
      check(diagActive, seed[8]);
    end
    avs(1'b1, IDX_IF_CTRL, 8'h41);
    avs(1'b1, IDX_AUX_CTRL, 8'hF3);
    host.access(1'b1, 1'b1, HA_HCTL, 8'h04);
    host.access(1'b1, 1'b1, HA_HCTL, 8'h00);
    rdChk(IDX_IF_CTRL, 8'h00);
    rdChk(IDX_AUX_CTRL, 8'h00);
    avs(1'b0, IDX_IF_STATUS, 8'h00);
    check(rd[5], 1'b1);
    avs(1'b0, IDX_IF_STATUS, 8'h00);
    check(rd[5], 1'b0);
    for (int d = 0; d < 2; d++)
    begin
      v = d ? 8'h36 : 8'hBE;
      avs(1'b1, IDX_DRV_OVR, v);
      check(hostBusy, v[DO_BUSY]);
      host.access(1'b1, 1'b0, HA_SDH, d ? 8'h10 : 8'h00);
      host.access(1'b1, 1'b0, HA_CMD, 8'h20);
      e = drvAfterCmd(v, d[0]);
      rdChk(IDX_DRV_OVR, e & 8'hBF);
      check({writeFault, driveNotReady, seekDone}, {e[4], e[1], e[5], e[2], e[3], e[0]});
      avs(1'b0, IDX_IF_STATUS, 8'h00);
      check(rd[2:1], {1'b1, v[DO_BUSY]});
    end
    @(posedge core_clk);
    driveReadyN <= 2'h3;
    repeat (5) @(posedge core_clk);
    check(driveNotReady, 2'h3);
    driveReadyN <= 2'h0;
    pulse(0);
    avs(1'b0, IDX_IF_STATUS, 8'h00);
    check(rd[2], 1'b0);
    avs(1'b1, IDX_DRV_OVR, 8'hC0);
    check({hostIrq, hostBusy}, 2'h2);
    avs(1'b1, IDX_DRV_OVR, 8'h80);
    check({hostIrq, hostBusy}, 2'h3);
    rdChk(IDX_DRV_OVR, 8'h80);
    avs(1'b0, IDX_IF_STATUS, 8'h00);
    check(rd[1:0], 2'h3);
    for (int k = 0; k < 2; k++)
    begin
      avs(1'b1, IDX_DRV_OVR, 8'h00);
      avs(1'b1, IDX_IF_CTRL, k ? 8'h04 : 8'h00);
      pulse(2);
      check(hostBusy, k[0]);
    end
    @(posedge core_clk);
    fifoHasData <= 1'b1;
    avs(1'b1, IDX_IF_CTRL, 8'h90);
    check(hostDrq, 1'b1);
    pulse(2);
    check(xferEnable, 1'b1);
    pulse(1);
    rdChk(IDX_IF_CTRL, 8'h10);
    avs(1'b1, IDX_IF_CTRL, 8'h80);
    pulse(2);
    check(xferEnable, 1'b0);
    @(posedge core_clk);
    {fifoHasData, wordXfer} <= 2'h1;
    for (int k = 0; k < 2; k++)
    begin
      avs(1'b1, IDX_IF_CTRL, k ? 8'h03 : 8'h00);
      sawCs16 = 1'b0;
      sawWait = 1'b0;
      host.access(1'b0, 1'b0, HA_DATA, 8'h00);
      check({sawCs16, sawWait}, k ? 2'h3 : 2'h0);
    end
    @(posedge core_clk);
    dataAvailable <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      avs(1'b1, IDX_AUX_CTRL, k ? 8'hF0 : 8'h00);
      sawWait = 1'b0;
      host.access(1'b0, 1'b0, HA_DATA, 8'h00);
      check(sawWait, k[0]);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      {masterMode, cmdInN, slavePassInput} <= {1'b1, k[0], k[0]};
      repeat (4) @(posedge core_clk);
      avs(1'b0, IDX_IF_STATUS, 8'h00);
      check(rd[4:3], k ? 2'h0 : 2'h3);
    end
    for (int k = 0; k < 2; k++)
    begin
      host.access(1'b1, 1'b1, HA_HCTL, k ? 8'h00 : 8'h02);
      check(hostIrqOeN, !k[0]);
    end
    avs(1'b1, IDX_DRV_OVR, 8'h00);
    avs(1'b1, IDX_IF_CTRL, 8'h08);
    check(hostIrqOeN, 1'b0);
    host.access(1'b0, 1'b0, HA_CMD, 8'h00);
    check(hostIrqOeN, 1'b1);
    complete_run();
  end
endmodule : tb_top
